// ===== logic/ssmf_pkg.sv
package ssmf_pkg;

  // register byte offsets on the apb side
  localparam logic [7:0] PORT_ONE_CONTROL_TWO_OFS = 8'h00;
  localparam logic [7:0] PORT_TWO_CONTROL_TWO_OFS = 8'h04;
  localparam logic [7:0] HOST_PORT_CONTROL_TWO_OFS = 8'h08;
  localparam logic [7:0] GLOBAL_SWITCH_CONTROL_TWO_OFS = 8'h0c;
  localparam logic [7:0] POLICY_STATUS_OFS = 8'h10;

  // per-port control two field positions
  localparam int PC_TX_EN = 0;
  localparam int PC_RX_EN = 1;
  localparam int PC_LEARN_DIS = 2;
  localparam int PC_RX_SNIFF = 3;
  localparam int PC_TX_SNIFF = 4;
  localparam int PC_SNIFFER = 5;
  localparam int PC_WIDTH = 6;

  // global switch control two field positions
  localparam int GC_BAD_TO_SNIFFER = 1;
  localparam int GC_MIRROR_AND = 8;
  localparam int GC_LISTENER_OPT = 12;
  localparam int GC_LISTENER_EN = 13;
  localparam int GC_WIDTH = 16;

  // reset values: network ports come up forwarding, nothing mirrored
  localparam logic [5:0] PC_NET_RST = 6'h03;
  localparam logic [5:0] PC_HOST_RST = 6'h03;
  localparam logic [15:0] GC_RST = 16'h0000;

  // port numbering and masks
  localparam int NPORT = 3;
  localparam logic [1:0] PORT_ONE = 2'h0;
  localparam logic [1:0] PORT_TWO = 2'h1;
  localparam logic [1:0] PORT_HOST = 2'h2;
  localparam logic [2:0] MASK_HOST = 3'h4;
  localparam logic [2:0] MASK_NONE = 3'h0;

  // header field codes for trapping
  localparam logic [3:0] IP_VER4 = 4'h4;
  localparam logic [7:0] PROTO_GROUP_MGMT = 8'h02;
  localparam logic [7:0] HOP_LIMIT_ONE = 8'h01;
  localparam logic [7:0] NH_HOP_BY_HOP = 8'h00;
  localparam logic [7:0] NH_ICMP4 = 8'h01;
  localparam logic [7:0] NH_ICMP6 = 8'h3a;
  localparam logic [7:0] NH_ROUTING = 8'h2b;
  localparam logic [7:0] NH_FRAGMENT = 8'h2c;
  localparam logic [7:0] NH_ESP = 8'h32;
  localparam logic [7:0] NH_AUTH = 8'h33;
  localparam logic [7:0] NH_DEST_OPT = 8'h3c;

  // one packet as handed over by the lookup engine
  typedef struct packed {
    logic [1:0] src_port;
    logic [2:0] lookup_mask;
    logic static_hit;
    logic static_override;
    logic [2:0] static_mask;
    logic bad_frame;
    logic is_ipv4;
    logic [3:0] ip_version;
    logic [7:0] ip_protocol;
    logic is_ipv6_mcast;
    logic [7:0] hop_limit;
    logic [7:0] next_header;
    logic [7:0] hbh_next_header;
  } ssmf_pkt_t;

  // forwarding verdict for one packet
  typedef struct packed {
    logic [2:0] dest_mask;
    logic learn;
    logic trapped;
    logic mirrored;
  } ssmf_verdict_t;

endpackage

// ===== logic/ssmf_filter.sv
`timescale 1ns/1ps
// How it works
// - host port is processor port; network ports stateful
// - disabled port: no traffic, no learning
// - override static entries may still reach processor
// - blocking: only packets to processor forwarded
// - listening: processor traffic only, no learning
// - learning: processor traffic only, learning on
// - forwarding: normal traffic and learning
// - trap ipv4 group management packets to host
// - static multicast entry trims to subscribed ports
// - listener snooping enable and option bits
// - trap hop limit one, header 1 or 58
// - option adds headers 43 44 50 51 60
// - receive sniff copies received packets to sniffer
// - optional bad received frames to sniffer
// - transmit sniff copies transmitted packets to sniffer
// - and-mode mirrors only rx-sniff to tx-sniff
// - any ports sniff, any port sniffer, per-port
module ssmf_filter (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // packet descriptors from the lookup engine
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire ssmf_pkg::ssmf_pkt_t pkt_in,
  // verdicts toward the queue manager
  output logic vrd_valid,
  input wire logic vrd_ready,
  output ssmf_pkg::ssmf_verdict_t vrd_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  // control words; ports store only field bits, the global word its low 16 bits
  // unstored upper bits read as zero
  logic [5:0] port_one_control_two_r;
  logic [5:0] port_two_control_two_r;
  logic [5:0] host_port_control_two_r;
  logic [15:0] global_switch_control_two_r;
  // status counters and read data
  logic [15:0] trap_count_r;
  logic [15:0] trap_count_nxt;
  logic [15:0] mirror_count_r;
  logic [15:0] mirror_count_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  // phase and address decode
  wire logic setup_ph;
  wire logic access_ph;
  wire logic wr_en;
  wire logic hit_p1;
  wire logic hit_p2;
  wire logic hit_p3;
  wire logic hit_gc;
  wire logic hit_st;
  wire logic mapped;

  // every access finishes on its first access cycle
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_p1 = (paddr == ssmf_pkg::PORT_ONE_CONTROL_TWO_OFS);
  assign hit_p2 = (paddr == ssmf_pkg::PORT_TWO_CONTROL_TWO_OFS);
  assign hit_p3 = (paddr == ssmf_pkg::HOST_PORT_CONTROL_TWO_OFS);
  assign hit_gc = (paddr == ssmf_pkg::GLOBAL_SWITCH_CONTROL_TWO_OFS);
  assign hit_st = (paddr == ssmf_pkg::POLICY_STATUS_OFS);
  assign mapped = hit_p1 | hit_p2 | hit_p3 | hit_gc | hit_st;
  assign wr_en = access_ph & pwrite & mapped;
  // unmapped address: error, nothing stored
  assign pready = access_ph;
  assign pslverr = access_ph & ~mapped;
  assign prdata = prdata_r;

  // read data is captured in the setup cycle so prdata leaves a flop
  always_comb begin
    // an unmapped address reads as zero
    prdata_nxt = 32'h0000_0000;
    if (hit_p1) begin
      prdata_nxt = {26'h0, port_one_control_two_r};
    end else if (hit_p2) begin
      prdata_nxt = {26'h0, port_two_control_two_r};
    end else if (hit_p3) begin
      prdata_nxt = {26'h0, host_port_control_two_r};
    end else if (hit_gc) begin
      prdata_nxt = {16'h0, global_switch_control_two_r};
    end else if (hit_st) begin
      prdata_nxt = {mirror_count_r, trap_count_r};
    end
  end

  // a flop keeps prdata off the decode path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= prdata_nxt;
    end
  end

  // control writes; the status word ignores writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // network ports come up forwarding
      port_one_control_two_r <= ssmf_pkg::PC_NET_RST;
      port_two_control_two_r <= ssmf_pkg::PC_NET_RST;
      host_port_control_two_r <= ssmf_pkg::PC_HOST_RST;
      global_switch_control_two_r <= ssmf_pkg::GC_RST;
    end else if (wr_en) begin
      // upper bus bits are dropped
      if (hit_p1) port_one_control_two_r <= pwdata[5:0];
      if (hit_p2) port_two_control_two_r <= pwdata[5:0];
      if (hit_p3) host_port_control_two_r <= pwdata[5:0];
      if (hit_gc) global_switch_control_two_r <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port state vectors, index 0 port one, 1 port two, 2 host

  // fields gathered per port, indexed by source
  // so selection needs no repeated decode
  wire logic [2:0] tx_en_v;
  wire logic [2:0] rx_en_v;
  wire logic [2:0] learn_dis_v;
  wire logic [2:0] rx_sniff_v;
  wire logic [2:0] tx_sniff_v;
  wire logic [2:0] sniffer_v;

  // the host port is the processor's own port; its enables are ignored
  assign tx_en_v = {1'b1, port_two_control_two_r[ssmf_pkg::PC_TX_EN],
                    port_one_control_two_r[ssmf_pkg::PC_TX_EN]};
  assign rx_en_v = {1'b1, port_two_control_two_r[ssmf_pkg::PC_RX_EN],
                    port_one_control_two_r[ssmf_pkg::PC_RX_EN]};
  // learn and sniff bits count for the host too
  assign learn_dis_v = {host_port_control_two_r[ssmf_pkg::PC_LEARN_DIS],
                        port_two_control_two_r[ssmf_pkg::PC_LEARN_DIS],
                        port_one_control_two_r[ssmf_pkg::PC_LEARN_DIS]};
  assign rx_sniff_v = {host_port_control_two_r[ssmf_pkg::PC_RX_SNIFF],
                       port_two_control_two_r[ssmf_pkg::PC_RX_SNIFF],
                       port_one_control_two_r[ssmf_pkg::PC_RX_SNIFF]};
  assign tx_sniff_v = {host_port_control_two_r[ssmf_pkg::PC_TX_SNIFF],
                       port_two_control_two_r[ssmf_pkg::PC_TX_SNIFF],
                       port_one_control_two_r[ssmf_pkg::PC_TX_SNIFF]};
  assign sniffer_v = {host_port_control_two_r[ssmf_pkg::PC_SNIFFER],
                      port_two_control_two_r[ssmf_pkg::PC_SNIFFER],
                      port_one_control_two_r[ssmf_pkg::PC_SNIFFER]};

  ////////////////////////////////////////////////////////////////////////////
  // source port qualifiers

  // tree states by their three bits:
  //   disabled, blocking, listening: tx 0, rx 0, no learn
  //   learning: tx 0, rx 0, learn
  //   forwarding: tx 1, rx 1, learn
  // the first three differ only in software's behaviour,
  // so the logic need not tell them apart
  wire logic [1:0] src;
  wire logic src_legal;
  wire logic src_is_host;
  wire logic src_rx_ok;
  wire logic src_learn;
  wire logic src_rx_sniff;

  // source code 3 names no port and goes nowhere unless trapped, then only to the host
  assign src = pkt_in.src_port;
  assign src_legal = (src != 2'h3);
  assign src_is_host = (src == ssmf_pkg::PORT_HOST);
  assign src_rx_ok = src_legal & rx_en_v[src];
  // learning follows the learning disable bit and the bad-frame flag, not the enables
  assign src_learn = src_legal & ~learn_dis_v[src] & ~pkt_in.bad_frame
                     & pkt_valid;
  assign src_rx_sniff = src_legal & rx_sniff_v[src];

  ////////////////////////////////////////////////////////////////////////////
  // trap classification

  // packets that must reach only the processor
  wire logic group_mgmt;
  wire logic nh_basic;
  wire logic hbh_basic;
  wire logic nh_ext;
  wire logic hbh_ext;
  wire logic via_hbh;
  wire logic listener_en;
  wire logic listener_opt;
  wire logic listener;
  wire logic trap;

  // ethernet and snap ipv4 both arrive flagged is_ipv4
  assign group_mgmt = pkt_in.is_ipv4
                      & (pkt_in.ip_version == ssmf_pkg::IP_VER4)
                      & (pkt_in.ip_protocol
                         == ssmf_pkg::PROTO_GROUP_MGMT);

  // snooping controls from the global word
  assign listener_en =
    global_switch_control_two_r[ssmf_pkg::GC_LISTENER_EN];
  assign listener_opt =
    global_switch_control_two_r[ssmf_pkg::GC_LISTENER_OPT];
  // one extension header deep at most; longer
  // chains are not followed
  assign via_hbh = (pkt_in.next_header == ssmf_pkg::NH_HOP_BY_HOP);

  // codes tried directly and behind hop-by-hop
  assign nh_basic = (pkt_in.next_header == ssmf_pkg::NH_ICMP4)
                  | (pkt_in.next_header == ssmf_pkg::NH_ICMP6);
  assign hbh_basic = via_hbh
                   & ((pkt_in.hbh_next_header == ssmf_pkg::NH_ICMP4)
                   | (pkt_in.hbh_next_header == ssmf_pkg::NH_ICMP6));
  assign nh_ext = (pkt_in.next_header == ssmf_pkg::NH_ROUTING)
                | (pkt_in.next_header == ssmf_pkg::NH_FRAGMENT)
                | (pkt_in.next_header == ssmf_pkg::NH_ESP)
                | (pkt_in.next_header == ssmf_pkg::NH_AUTH)
                | (pkt_in.next_header == ssmf_pkg::NH_DEST_OPT);
  assign hbh_ext = via_hbh
                 & ((pkt_in.hbh_next_header == ssmf_pkg::NH_ROUTING)
                 | (pkt_in.hbh_next_header == ssmf_pkg::NH_FRAGMENT)
                 | (pkt_in.hbh_next_header == ssmf_pkg::NH_ESP)
                 | (pkt_in.hbh_next_header == ssmf_pkg::NH_AUTH)
                 | (pkt_in.hbh_next_header
                    == ssmf_pkg::NH_DEST_OPT));

  // multicast and hop limit gate every header test
  assign listener = listener_en & pkt_in.is_ipv6_mcast
                  & (pkt_in.hop_limit == ssmf_pkg::HOP_LIMIT_ONE)
                  & (nh_basic | hbh_basic
                  | (listener_opt & (nh_ext | hbh_ext)));

  // the processor's own packets are never trapped back to it
  assign trap = (group_mgmt | listener) & ~src_is_host;

  ////////////////////////////////////////////////////////////////////////////
  // destination selection

  // mask bits: 0 port one, 1 port two, 2 host
  wire logic [2:0] base_mask;
  wire logic [2:0] override_mask;
  wire logic [2:0] rx_mask;
  wire logic [2:0] tx_gate;
  wire logic [2:0] fwd_mask;
  wire logic [2:0] no_self;
  wire logic rx_mirror;
  wire logic tx_mirror;
  wire logic mirror_and;
  wire logic mirror_hit;
  wire logic bad_pass;
  wire logic [2:0] final_mask;
  wire logic mirrored;

  // static entry wins over the dynamic result, trimming multicast
  assign base_mask = pkt_in.static_hit ? pkt_in.static_mask
                                       : pkt_in.lookup_mask;

  // a port that does not receive can only feed overriding entries
  // toward the processor; apart from traps nothing else escapes it
  assign override_mask = (pkt_in.static_hit & pkt_in.static_override)
                         ? (pkt_in.static_mask & ssmf_pkg::MASK_HOST)
                         : ssmf_pkg::MASK_NONE;

  // a trap wins even on a port that receives nothing
  assign rx_mask = trap ? ssmf_pkg::MASK_HOST
                 : src_rx_ok ? base_mask
                 : override_mask;

  // processor frames may leave a port whose transmit enable is clear
  assign tx_gate = src_is_host ? 3'h7 : tx_en_v;

  // a packet never goes back out the port it came in on, except as a sniffer copy
  assign no_self = src_legal ? ~(3'h1 << src) : 3'h7;
  assign fwd_mask = rx_mask & tx_gate & no_self & {3{src_legal}};

  // mirror decision works on the ports the packet really leaves by
  assign rx_mirror = src_rx_sniff & (src_rx_ok | src_is_host);
  assign tx_mirror = |(fwd_mask & tx_sniff_v);
  assign mirror_and =
    global_switch_control_two_r[ssmf_pkg::GC_MIRROR_AND];
  assign mirror_hit = mirror_and ? (rx_mirror & tx_mirror)
                                 : (rx_mirror | tx_mirror);

  // bad frames are dropped unless the option sends them to the sniffer
  assign bad_pass = global_switch_control_two_r[ssmf_pkg::GC_BAD_TO_SNIFFER]
                    & rx_mirror;

  // trapped packets go only to the host, never copied elsewhere
  assign final_mask = pkt_in.bad_frame
                      ? (bad_pass ? sniffer_v : ssmf_pkg::MASK_NONE)
                      : trap ? ssmf_pkg::MASK_HOST
                      : (mirror_hit ? (fwd_mask | sniffer_v)
                                    : fwd_mask);
  // mirrored: a copy went to the sniffer
  assign mirrored = pkt_in.bad_frame ? bad_pass
                  : (~trap & mirror_hit);

  ////////////////////////////////////////////////////////////////////////////
  // two-entry verdict buffer; a stalled consumer halts the lookup side

  // two entries let the source run at full rate
  // while the consumer answers a cycle late
  ssmf_pkg::ssmf_verdict_t buf_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] level_r;
  logic [1:0] level_nxt;
  wire logic push;
  wire logic pop;
  ssmf_pkg::ssmf_verdict_t verdict;

  // verdict fields as they enter the buffer
  assign verdict.dest_mask = final_mask;
  assign verdict.learn = src_learn;
  assign verdict.trapped = trap & ~pkt_in.bad_frame;
  assign verdict.mirrored = mirrored;

  // flags come straight from the level flop
  assign pkt_ready = (level_r != 2'h2);
  assign vrd_valid = (level_r != 2'h0);
  assign push = pkt_valid & pkt_ready;
  assign pop = vrd_valid & vrd_ready;
  assign vrd_out = buf_r[rd_ptr_r];
  assign level_nxt = level_r + {1'b0, push} - {1'b0, pop};

  // storage and pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      level_r <= 2'h0;
    end else begin
      if (push) buf_r[wr_ptr_r] <= verdict;
      if (push) wr_ptr_r <= ~wr_ptr_r;
      if (pop) rd_ptr_r <= ~rd_ptr_r;
      // push and pop together keep the level
      level_r <= level_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event counters; they wrap rather than saturate to keep them cheap

  // counted as a verdict enters the buffer
  assign trap_count_nxt = trap_count_r
                          + {15'h0, push & verdict.trapped};
  assign mirror_count_nxt = mirror_count_r
                            + {15'h0, push & verdict.mirrored};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // cleared only by reset
      trap_count_r <= 16'h0000;
      mirror_count_r <= 16'h0000;
    end else begin
      trap_count_r <= trap_count_nxt;
      mirror_count_r <= mirror_count_nxt;
    end
  end

endmodule // ssmf_filter

// ===== test/ssmf_filter_asserts.sv
`timescale 1ns/1ps
module ssmf_filter_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // packet and verdict streams
  input wire logic pkt_valid,
  input wire logic pkt_ready,
  input wire ssmf_pkg::ssmf_pkt_t pkt_in,
  input wire logic vrd_valid,
  input wire logic vrd_ready,
  input wire ssmf_pkg::ssmf_verdict_t vrd_out
);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] ctl_r [4];
  logic [1:0] lvl_r;
  logic [1:0] s;
  logic acc, pop, wr, plain, igmp, ldis;
  logic [2:0] snf, lim;
  // shadow of the control words; misaligned writes are never issued
  assign s = pkt_in.src_port;
  assign acc = pkt_valid && pkt_ready;
  assign pop = vrd_valid && vrd_ready;
  assign wr = psel && penable && pwrite && paddr < 8'h10;
  assign plain = !pkt_in.bad_frame && !pkt_in.is_ipv4 && !pkt_in.is_ipv6_mcast;
  assign igmp = pkt_in.is_ipv4 && pkt_in.ip_version == 4'h4 &&
    pkt_in.ip_protocol == 8'h02 && !pkt_in.bad_frame;
  assign snf = {ctl_r[2][5], ctl_r[1][5], ctl_r[0][5]};
  assign lim = pkt_in.static_mask | snf;
  assign ldis = ctl_r[s][2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= '{16'h0003, 16'h0003, 16'h0003, 16'h0000};
      lvl_r <= 2'h0;
    end else begin
      if (wr) ctl_r[paddr[3:2]] <= pwdata[15:0];
      lvl_r <= lvl_r + 2'(acc) - 2'(pop);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // a verdict that meets an empty buffer shows up alone one cycle later
  sequence net_acc;
    acc && !vrd_valid && s < 2'h2;
  endsequence
  bus_err_a: assert property (psel && penable |->
    pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
    else $error("slave error does not match address");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("no ready in an access cycle");
  buf_level_a: assert property (pkt_ready == (lvl_r != 2'h2) &&
    vrd_valid == (lvl_r != 2'h0)) else $error("buffer flags off");
  vrd_hold_a: assert property (vrd_valid && !vrd_ready |=>
    vrd_valid && $stable(vrd_out)) else $error("verdict not held");
  trap_host_a: assert property (net_acc ##0 igmp |=>
    vrd_out.trapped && vrd_out.dest_mask == 3'h4 && !vrd_out.mirrored)
    else $error("group packet not trapped");
  rx_off_a: assert property (net_acc ##0 plain && !ctl_r[s][1] &&
    !pkt_in.static_override |=> vrd_out.dest_mask == 3'h0)
    else $error("disabled port passed traffic");
  learn_gate_a: assert property (net_acc ##0 !pkt_in.bad_frame |=>
    vrd_out.learn == !$past(ldis)) else $error("learn flag wrong");
  host_tx_a: assert property (acc && !vrd_valid && s == 2'h2 &&
    !pkt_in.bad_frame && !pkt_in.static_hit && pkt_in.lookup_mask[0]
    |=> vrd_out.dest_mask[0]) else $error("host packet held back");
  static_trim_a: assert property (net_acc ##0 plain &&
    pkt_in.static_hit |=> (vrd_out.dest_mask & ~$past(lim)) == 3'h0)
    else $error("static entry not trimmed");
  rx_copy_a: assert property (net_acc ##0 plain && ctl_r[s][1] &&
    ctl_r[s][3] && !ctl_r[3][8] |=> vrd_out.mirrored &&
    (vrd_out.dest_mask & $past(snf)) == $past(snf))
    else $error("received packet not copied");
endmodule // ssmf_filter_asserts

bind ssmf_filter ssmf_filter_asserts chk (.*);

// ===== test/ssmf_sink.sv
`timescale 1ns/1ps
// queue manager side; when slow it stalls three cycles in four on average
module ssmf_sink (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pace chosen by the bench
  input wire logic slow,
  // verdict handshake
  output logic vrd_ready
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) vrd_ready <= 1'b0;
    else vrd_ready <= slow ? ($urandom_range(3) == 0) : 1'b1;
  end
endmodule // ssmf_sink

// ===== test/test_stp_snoop_mirror_filter.sv
`timescale 1ns/1ps
module test_stp_snoop_mirror_filter;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pkt_valid, pkt_ready, vrd_valid, vrd_ready, slow, er;
  ssmf_pkg::ssmf_pkt_t pkt_in, p;
  ssmf_pkg::ssmf_verdict_t vrd_out;
  ssmf_pkg::ssmf_verdict_t expq [$];
  logic [15:0] rg [4];
  logic [7:0] nhs [8];
  logic [3:0] st [4];
  int err_count, samples_checked, cyc, tc, mc;
  ////////////////////////////////////////////////////////////////////////////
  ssmf_filter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_in(pkt_in),
    .vrd_valid(vrd_valid), .vrd_ready(vrd_ready), .vrd_out(vrd_out));
  ssmf_sink sink (.pclk(pclk), .presetn(presetn), .slow(slow),
    .vrd_ready(vrd_ready));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // idle edge first so two transfers never share a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a < 8'h10)
      rg[a[3:2]] = d[15:0] & (a == 8'h0c ? 16'hffff : 16'h003f);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic x);
    apb(1'b0, a, 32'h0);
    cmp("read data", e, rd);
    cmp("slave error", 32'(x), 32'(er));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic lst(input logic [7:0] x);
    return x == 8'h01 || x == 8'h3a || rg[3][12] && (x == 8'h2b ||
      x == 8'h2c || x == 8'h32 || x == 8'h33 || x == 8'h3c);
  endfunction
  // expected verdict from the current control words
  function automatic ssmf_pkg::ssmf_verdict_t model(ssmf_pkg::ssmf_pkt_t q);
    ssmf_pkg::ssmf_verdict_t v;
    logic [15:0] c;
    logic [2:0] f, snf, txs;
    logic rxon, rxm, m, t;
    c = rg[q.src_port];
    snf = {rg[2][5], rg[1][5], rg[0][5]};
    txs = {rg[2][4], rg[1][4], rg[0][4]};
    rxon = c[1] || q.src_port == 2'h2;
    f = q.static_hit ? q.static_mask : q.lookup_mask;
    if (!rxon) f = q.static_hit && q.static_override ? f & 3'h4 : 3'h0;
    if (q.src_port != 2'h2) f = f & {1'b1, rg[1][0], rg[0][0]};
    f[q.src_port] = 1'b0;
    rxm = c[3] && rxon;
    m = rg[3][8] ? rxm && |(f & txs) : rxm || |(f & txs);
    t = q.is_ipv4 && q.ip_version == 4'h4 && q.ip_protocol == 8'h02 ||
      rg[3][13] && q.is_ipv6_mcast && q.hop_limit == 8'h01 &&
      (lst(q.next_header) || q.next_header == 8'h00 && lst(q.hbh_next_header));
    v.learn = !c[2];
    v.trapped = t && q.src_port != 2'h2;
    v.mirrored = m && !v.trapped;
    v.dest_mask = v.trapped ? 3'h4 : f | (m ? snf : 3'h0);
    if (q.bad_frame) begin
      v.mirrored = rg[3][1] && rxm;
      v.dest_mask = v.mirrored ? snf : 3'h0;
      v.learn = 1'b0;
    end
    return v;
  endfunction
  // network sources only; a bad frame never looks like a trap candidate
  function automatic ssmf_pkg::ssmf_pkt_t rpkt();
    ssmf_pkg::ssmf_pkt_t q;
    logic [63:0] r;
    r = {$urandom, $urandom};
    q = r[$bits(q)-1:0];
    q.src_port[1] = 1'b0;
    if (r[63]) q.ip_version = 4'h4;
    if (r[62]) q.ip_protocol = 8'h02;
    if (r[61]) q.hop_limit = 8'h01;
    if (r[60]) q.next_header = nhs[r[59:57]];
    if (r[56]) q.hbh_next_header = nhs[r[55:53]];
    q.bad_frame = r[52:50] == 3'h0;
    if (q.bad_frame) {q.is_ipv4, q.is_ipv6_mcast} = 2'h0;
    return q;
  endfunction
  // valid stays up between packets; drain lowers it
  task automatic send(input ssmf_pkg::ssmf_pkt_t q);
    ssmf_pkg::ssmf_verdict_t v;
    v = model(q);
    pkt_in <= q;
    pkt_valid <= 1'b1;
    do @(posedge pclk); while (pkt_ready !== 1'b1);
    expq.push_back(v);
    tc += int'(v.trapped);
    mc += int'(v.mirrored);
  endtask
  task automatic drain();
    pkt_valid <= 1'b0;
    while (expq.size() != 0) @(posedge pclk);
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // hang guard, then the oldest note against each verdict taken
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      end_of_test();
    end
  end
  always @(posedge pclk) begin
    if (presetn === 1'b1 && vrd_valid === 1'b1 && vrd_ready === 1'b1) begin
      if (expq.size() == 0) cmp("spare verdict", 32'h0, 32'h1);
      else cmp("verdict", 32'(expq.pop_front()), 32'(vrd_out));
    end
  end
  initial begin
    {psel, penable, pwrite, pkt_valid, slow} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pkt_in = '0;
    nhs = '{8'h01, 8'h3a, 8'h2b, 8'h2c, 8'h32, 8'h33, 8'h3c, 8'h00};
    rg = '{16'h0003, 16'h0003, 16'h0003, 16'h0000};
    st = '{4'h4, 4'hc, 4'h8, 4'hb};
    presetn = 1'b0;
    void'($urandom(26));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped and read-only places, bits above the fields
    foreach (rg[i]) rchk(8'(4 * i), 32'(rg[i]), 1'b0);
    rchk(8'h10, 32'h0, 1'b0);
    rchk(8'h14, 32'h0, 1'b1);
    wreg(8'h10, 32'hffffffff);
    wreg(8'h00, 32'hffffffff);
    rchk(8'h00, 32'h3f, 1'b0);
    rchk(8'h10, 32'h0, 1'b0);
    // each tree state on port one; bit 3 marks where the host may send
    wreg(8'h08, 32'h23);
    foreach (st[i]) begin
      wreg(8'h00, 32'(st[i][2:0]) | 32'h8);
      p = '0;
      p.lookup_mask = 3'h2;
      send(p);
      p.static_hit = 1'b1;
      p.static_override = 1'b1;
      p.static_mask = 3'h4;
      send(p);
      p = '0;
      p.src_port = 2'h1;
      p.lookup_mask = 3'h1;
      send(p);
      p.src_port = 2'h2;
      if (st[i][3]) begin
        drain();
        send(p);
      end
      drain();
    end
    // every listener header code, direct and behind a hop-by-hop header
    for (int g = 0; g < 4; g++) begin
      wreg(8'h0c, 32'(g) << 12);
      foreach (nhs[i]) begin
        p = '0;
        p.is_ipv6_mcast = 1'b1;
        p.hop_limit = 8'h01;
        p.lookup_mask = 3'h2;
        p.next_header = nhs[i];
        send(p);
        p.hbh_next_header = nhs[i];
        p.next_header = 8'h00;
        send(p);
      end
      drain();
    end
    // random policies and sniffers; a slow sink fills the buffer
    for (int k = 0; k < 40; k++) begin
      wreg(8'h00, $urandom & 32'h1f);
      wreg(8'h04, $urandom & 32'h3f);
      wreg(8'h08, $urandom & 32'h33);
      wreg(8'h0c, $urandom & 32'h3102);
      slow <= k[0];
      repeat (8) send(rpkt());
      drain();
    end
    rchk(8'h10, {mc[15:0], tc[15:0]}, 1'b0);
    end_of_test();
  end
endmodule // test_stp_snoop_mirror_filter
